// *** hw/adcc_top.sv ***
// Purpose: control logic of an eight channel, 10-bit successive approximation converter
// Assumes: analog core supplies a comparator level, high when input >= trial code
// Notes: registers reached over ahb-lite with zero wait states
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module adcc_top import adcc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic comparator_in,
   output logic [9:0] sar_code,
   output logic [2:0] analog_channel,
   output logic adc_power_on,
   output logic [7:0] port_b_analog_lines,
   output logic conv_busy,
   output logic adc_irq
);

   adcc_addr_phase_type ap;
   adcc_control_type ctrl;
   adcc_control_type wr_ctrl;
   adcc_state_type state;
   logic [7:0] clock_setting;
   logic [9:0] result;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_mask;
   logic [3:0] bit_idx;
   logic [1:0] sample_count;
   logic comp_meta;
   logic comp_sync;
   logic tick;
   logic wr_control;
   logic start_rise;
   logic start_fall;
   logic finish;
   logic [9:0] final_code;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [7:0] analog_mask(input logic [2:0] cfg);
      if (cfg == 3'h7) begin
         return 8'hff;
      end
      return 8'((9'h001 << cfg) - 9'h001);
   endfunction

   function automatic logic [31:0] read_value(input logic [7:0] idx, input logic [7:0] c,
                                              input logic [7:0] cs, input logic [9:0] r,
                                              input logic [1:0] st, input logic [1:0] mk);
      if (idx == IDX_RESULT_LOW) begin
         return {24'h000000, r[1:0], 6'h00};
      end else if (idx == IDX_RESULT_HIGH) begin
         return {24'h000000, r[9:2]};
      end else if (idx == IDX_CONTROL) begin
         return {24'h000000, c};
      end else if (idx == IDX_CLOCK_SETTING) begin
         return {24'h000000, cs[CLKSET_TEST_BIT], 5'h00, cs[1:0]};
      end else if (idx == IDX_IRQ_STATUS) begin
         return {30'h00000000, st};
      end else if (idx == IDX_IRQ_MASK) begin
         return {30'h00000000, mk};
      end
      return 32'h00000000;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: always ready, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap <= '0;
      end else if (hready) begin
         ap.valid <= hsel && htrans[1] && (hsize == 3'h2) && (haddr[31:10] == 22'h000000)
                     && (haddr[1:0] == 2'h0);
         ap.write <= hwrite;
         ap.index <= haddr[9:2];
      end
   end

   // read data is captured in the address phase so it comes from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= read_value(haddr[9:2], ctrl, clock_setting, result, irq_status, irq_mask);
      end
   end

   assign wr_control = ap.valid && ap.write && (ap.index == IDX_CONTROL);
   assign wr_ctrl = adcc_control_type'(hwdata[7:0]);
   assign start_rise = wr_control && wr_ctrl.start && !ctrl.start;
   assign start_fall = wr_control && !wr_ctrl.start && ctrl.start;

   ////////////////////////////////////////////////////////////////////////////////
   // control register; the done flag is hardware owned and ignores writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= adcc_control_type'(CONTROL_RESET);
      end else begin
         if (wr_control) begin
            ctrl.start <= wr_ctrl.start;
            ctrl.port_cfg <= wr_ctrl.port_cfg;
            ctrl.channel <= wr_ctrl.channel;
         end
         // a start rise wins over a finish in the same cycle (finish excludes it)
         if (start_rise) begin
            ctrl.done <= 1'b1;
         end else if (finish) begin
            ctrl.done <= 1'b0;
         end
      end
   end

   // port configuration drives pad control and converter power
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_b_analog_lines <= 8'h00;
         adc_power_on <= 1'b0;
      end else if (wr_control) begin
         port_b_analog_lines <= analog_mask(wr_ctrl.port_cfg);
         adc_power_on <= (wr_ctrl.port_cfg != 3'h0);
      end
   end

   // test bit is stored only so reads are coherent; it steers nothing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_setting <= CLOCK_SETTING_RESET;
      end else if (ap.valid && ap.write && (ap.index == IDX_CLOCK_SETTING)) begin
         clock_setting <= {hwdata[CLKSET_TEST_BIT], 5'h00, hwdata[1:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status (write one to clear, set wins) and mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= '0;
      end else begin
         for (int i = 0; i < IRQ_BITS; i++) begin
            if ((i == IRQ_DONE_BIT && finish) || (i == IRQ_RESET_BIT && start_rise)) begin
               irq_status[i] <= 1'b1;
            end else if (ap.valid && ap.write && (ap.index == IDX_IRQ_STATUS) && hwdata[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (ap.valid && ap.write && (ap.index == IDX_IRQ_MASK)) begin
         irq_mask <= hwdata[IRQ_BITS-1:0];
      end
   end

   assign adc_irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////////
   // comparator comes from the analog core, asynchronous to hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         comp_meta <= comparator_in;
         comp_sync <= comp_meta;
      end
   end

   adcc_clkdiv u_clkdiv (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(conv_busy),
      .div_select(clock_setting[CLKSET_DIV_LSB +: 2]),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // successive approximation sequencer; two periods per bit give the
   // comparator plus its synchroniser time to settle even at the fastest clock
   assign conv_busy = (state != ADCC_IDLE);
   assign final_code = comp_sync ? sar_code : (sar_code & ~(10'h001 << bit_idx));
   assign finish = (state == ADCC_DECIDE) && tick && (bit_idx == 4'h0) && !start_rise;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ADCC_IDLE;
         sar_code <= 10'h000;
         bit_idx <= 4'h0;
         sample_count <= 2'h0;
         analog_channel <= 3'h0;
      end else if (start_rise) begin
         state <= ADCC_IDLE;
         sar_code <= 10'h000;
      end else if (start_fall) begin
         state <= ADCC_SAMPLE;
         analog_channel <= wr_ctrl.channel;
         sar_code <= 10'h000;
         sample_count <= 2'h0;
      end else begin
         case (state)
            ADCC_IDLE: begin
               sample_count <= 2'h0;
            end
            ADCC_SAMPLE: begin
               if (tick) begin
                  sample_count <= sample_count + 2'h1;
                  if (sample_count == 2'(SAMPLE_PERIODS - 1)) begin
                     state <= ADCC_TRIAL;
                     bit_idx <= 4'(RESULT_BITS - 1);
                     sar_code <= 10'h200;
                  end
               end
            end
            ADCC_TRIAL: begin
               if (tick) begin
                  state <= ADCC_DECIDE;
               end
            end
            ADCC_DECIDE: begin
               if (tick) begin
                  if (bit_idx == 4'h0) begin
                     state <= ADCC_IDLE;
                     sar_code <= final_code;
                  end else begin
                     state <= ADCC_TRIAL;
                     sar_code <= final_code | (10'h001 << (bit_idx - 4'h1));
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
            default: begin
               state <= ADCC_IDLE;
            end
         endcase
      end
   end

   // result is only replaced at completion so a late read stays consistent
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result <= RESULT_RESET;
      end else if (finish) begin
         result <= final_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   logic [5:0] period_count;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_count <= 6'h00;
      end else if (!conv_busy || start_fall) begin
         period_count <= 6'h00;
      end else if (tick) begin
         period_count <= period_count + 6'h01;
      end
   end

   done_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      start_rise |=> ctrl.done && !conv_busy)
      else $error("done flag not set by start rise");

   done_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      finish |=> !ctrl.done && !conv_busy)
      else $error("done flag not cleared at finish");

   irq_with_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
      finish ##1 irq_mask[IRQ_DONE_BIT] |-> adc_irq && irq_status[IRQ_DONE_BIT])
      else $error("interrupt not raised at finish");

   result_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap.valid && !ap.write && ap.index == IDX_RESULT_LOW && !$past(finish))
      |-> hrdata[5:0] == 6'h00 && hrdata[7:6] == result[1:0])
      else $error("low result byte layout wrong");

   conv_length_a: assert property (@(posedge hclk) disable iff (!hresetn)
      finish |-> period_count == 6'(CONV_PERIODS - 1))
      else $error("conversion length wrong");

   chan_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      start_fall |=> analog_channel == ctrl.channel && state == ADCC_SAMPLE)
      else $error("channel not latched at start fall");

   power_cfg_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_control |=> adc_power_on == ($past(hwdata[5:3]) != 3'h0))
      else $error("converter power wrong");

   all_analog_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_control && hwdata[5:3] == 3'h7 |=> port_b_analog_lines == 8'hff)
      else $error("port b analog mask wrong");

   clkset_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ap.valid && !ap.write && ap.index == IDX_CLOCK_SETTING |-> hrdata[6:2] == 5'h00)
      else $error("unused clock setting bits not zero");

   div8_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tick && clock_setting[1:0] == DIV_SEL_8 && !wr_control
      |=> (!tick)[*7] ##1 (tick || !conv_busy))
      else $error("divide by eight spacing wrong");

endmodule

// *** hw/adcc_pkg.sv ***
// Purpose: shared constants and types for the a/d conversion control block
// Assumes: ahb-lite register access, 32-bit words, one register per aligned word
// Notes: register byte address is four times the register index
package adcc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register indices (byte address = index * 4)
   localparam logic [7:0] IDX_RESULT_LOW = 8'h24;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h25;
   localparam logic [7:0] IDX_CONTROL = 8'h26;
   localparam logic [7:0] IDX_CLOCK_SETTING = 8'h27;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h29;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions and widths
   localparam int RESULT_BITS = 10;
   localparam int CHANNEL_COUNT = 8;
   localparam int CLKSET_TEST_BIT = 7;
   localparam int CLKSET_DIV_LSB = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_RESET_BIT = 1;
   localparam int IRQ_BITS = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CLOCK_SETTING_RESET = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   ////////////////////////////////////////////////////////////////////////////////
   // conversion clock division, in system clock cycles
   localparam logic [1:0] DIV_SEL_2 = 2'h0;
   localparam logic [1:0] DIV_SEL_8 = 2'h1;
   localparam logic [1:0] DIV_SEL_32 = 2'h2;
   localparam logic [5:0] DIV2_CYCLES = 6'h02;
   localparam logic [5:0] DIV8_CYCLES = 6'h08;
   localparam logic [5:0] DIV32_CYCLES = 6'h20;

   // conversion length, in conversion clock periods
   localparam int SAMPLE_PERIODS = 2;
   localparam int BIT_PERIODS = 2;
   localparam int CONV_PERIODS = SAMPLE_PERIODS + BIT_PERIODS * RESULT_BITS;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      ADCC_IDLE = 4'b0001,
      ADCC_SAMPLE = 4'b0010,
      ADCC_TRIAL = 4'b0100,
      ADCC_DECIDE = 4'b1000
   } adcc_state_type;

   typedef struct packed {
      logic start;
      logic done;
      logic [2:0] port_cfg;
      logic [2:0] channel;
   } adcc_control_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] index;
   } adcc_addr_phase_type;

endpackage

// *** hw/adcc_clkdiv.sv ***
// Purpose: conversion clock tick generator, one hclk pulse per conversion period
// Assumes: select code 3 behaves as the slowest division
// Notes: counter restarts whenever run is low, so the first tick is one full period late
`timescale 1ns/10ps
module adcc_clkdiv import adcc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic [1:0] div_select,
   output logic tick
);

   logic [5:0] count;
   logic [5:0] last;

   always_comb begin
      if (div_select == DIV_SEL_2) begin
         last = DIV2_CYCLES - 6'h01;
      end else if (div_select == DIV_SEL_8) begin
         last = DIV8_CYCLES - 6'h01;
      end else begin
         last = DIV32_CYCLES - 6'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 6'h00;
         tick <= 1'b0;
      end else if (!run) begin
         count <= 6'h00;
         tick <= 1'b0;
      end else if (count >= last) begin
         count <= 6'h00;
         tick <= 1'b1;
      end else begin
         count <= count + 6'h01;
         tick <= 1'b0;
      end
   end

endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for the a/d conversion control block over ahb-lite
// Assumes: zero wait state slave, hready looped back from hreadyout
// Notes: comparator is modelled as an ideal input level so the sar must land on it exactly
`timescale 1ns/10ps
module tb import adcc_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic comparator_in = 1'b0;
   logic [9:0] sar_code;
   logic [2:0] analog_channel;
   logic adc_power_on;
   logic [7:0] port_b_analog_lines;
   logic conv_busy;
   logic adc_irq;
   logic [9:0] tgt = 10'h000;
   int num_errors = 0;
   int n_checks = 0;

   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   // ideal analog input held at tgt
   always @(posedge hclk) comparator_in <= (tgt >= sar_code);

   adcc_top DUT (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .comparator_in(comparator_in),
      .sar_code(sar_code),
      .analog_channel(analog_channel),
      .adc_power_on(adc_power_on),
      .port_b_analog_lines(port_b_analog_lines),
      .conv_busy(conv_busy),
      .adc_irq(adc_irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   // entered and left on a rising edge; the master never assumes a latency
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, idx, {24'h0, d}, x);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string name);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk(name, {24'h0, exp}, x);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // full start sequence, then completion timing, flags and result layout
   task automatic convert(input logic [1:0] code, input logic [2:0] ch, input logic [9:0] t);
      int n;
      int dv;
      logic [7:0] base;
      dv = (code == DIV_SEL_2) ? int'(DIV2_CYCLES) :
           ((code == DIV_SEL_8) ? int'(DIV8_CYCLES) : int'(DIV32_CYCLES));
      base = {2'b00, 3'h7, ch};
      tgt <= t;
      wr(IDX_CLOCK_SETTING, {6'h00, code});
      wr(IDX_CONTROL, base);
      // the rise carries another channel, so the fall must supply the one converted
      wr(IDX_CONTROL, (base ^ 8'h07) | 8'h80);
      rd_chk(IDX_CONTROL, (base ^ 8'h07) | 8'hc0, "done_after_rise");
      rd_chk(IDX_IRQ_STATUS, 8'h02, "status_reset_event");
      wr(IDX_IRQ_STATUS, 8'h02);
      wr(IDX_CONTROL, base);
      n = 0;
      do begin
         @(posedge hclk);
         #1;
         n++;
         if (n == 2) begin
            chk("busy_rise", 32'h1, {31'h0, conv_busy});
            chk("latched_channel", {29'h0, ch}, {29'h0, analog_channel});
         end
      end while ((n < 2 || conv_busy !== 1'b0) && n < 1000);
      @(posedge hclk);
      chk("conv_time_ok", 32'h1,
          {31'h0, (n >= CONV_PERIODS * dv && n <= CONV_PERIODS * dv + 2)});
      chk("irq_at_finish", 32'h1, {31'h0, adc_irq});
      rd_chk(IDX_CONTROL, base, "done_cleared");
      rd_chk(IDX_IRQ_STATUS, 8'h01, "status_done");
      rd_chk(IDX_RESULT_HIGH, t[9:2], "result_high");
      rd_chk(IDX_RESULT_LOW, {t[1:0], 6'h00}, "result_low");
      wr(IDX_IRQ_STATUS, 8'h01);
      settle(2);
      chk("irq_after_clear", 32'h0, {31'h0, adc_irq});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      end_sim;
   end

   initial begin
      logic [7:0] exp_lines;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(IDX_CONTROL, CONTROL_RESET, "control_reset");
      rd_chk(IDX_CLOCK_SETTING, CLOCK_SETTING_RESET, "clkset_reset");
      rd_chk(IDX_IRQ_MASK, 8'h00, "mask_reset");
      rd_chk(IDX_IRQ_STATUS, 8'h00, "status_reset");
      rd_chk(IDX_RESULT_HIGH, 8'h00, "result_high_reset");
      chk("power_reset", 32'h0, {31'h0, adc_power_on});
      // unmapped word reads zero and keeps nothing
      wr(8'h30, 8'h5a);
      rd_chk(8'h30, 8'h00, "unmapped");
      // software keeps the factory test bit clear
      wr(IDX_CLOCK_SETTING, 8'h7f);
      rd_chk(IDX_CLOCK_SETTING, 8'h03, "clkset_unused_zero");
      // every port configuration code
      for (int n = 0; n < 8; n++) begin
         exp_lines = (n == 7) ? 8'hff : ((8'h01 << n) - 8'h01);
         wr(IDX_CONTROL, {2'b00, n[2:0], 3'h0});
         settle(2);
         chk("analog_lines", {24'h0, exp_lines}, {24'h0, port_b_analog_lines});
         chk("power_on", {31'h0, n != 0}, {31'h0, adc_power_on});
      end
      wr(IDX_IRQ_MASK, 8'h03);
      rd_chk(IDX_IRQ_MASK, 8'h03, "mask_rw");
      convert(DIV_SEL_2, 3'h1, 10'h2a5);
      convert(DIV_SEL_8, 3'h6, 10'h15a);
      convert(DIV_SEL_32, 3'h3, 10'h3ff);
      convert(2'h3, 3'h0, 10'h001);
      convert(DIV_SEL_2, 3'h7, 10'h000);
      // results are read only and the done flag ignores writes
      wr(IDX_RESULT_HIGH, 8'hff);
      rd_chk(IDX_RESULT_HIGH, 8'h00, "result_high_ro");
      wr(IDX_CONTROL, 8'h67);
      rd_chk(IDX_CONTROL, 8'h27, "done_ro");
      // abort by a new rise mid conversion, with the reset event masked
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_CONTROL, 8'ha2);
      wr(IDX_CONTROL, 8'h22);
      wr(IDX_IRQ_STATUS, 8'h03);
      settle(10);
      chk("busy_mid", 32'h1, {31'h0, conv_busy});
      wr(IDX_CONTROL, 8'ha2);
      settle(2);
      chk("busy_abort", 32'h0, {31'h0, conv_busy});
      chk("irq_masked", 32'h0, {31'h0, adc_irq});
      rd_chk(IDX_IRQ_STATUS, 8'h02, "status_masked_set");
      rd_chk(IDX_CONTROL, 8'he2, "done_after_abort");
      end_sim;
   end
endmodule
